// ### pkg/tmrvd_consts.svh
// Widths and phase encodings for the TMR voter block
`ifndef TMRVD_CONSTS_SVH
`define TMRVD_CONSTS_SVH
`define TMRVD_SIG_W 8
`define TMRVD_OP_W 8
`define TMRVD_MEM_W 16
`define TMRVD_PH_W 2
`define TMRVD_PH_W_CODE 2'h0
`define TMRVD_PH_X_CODE 2'h1
`define TMRVD_PH_Y_CODE 2'h2
`define TMRVD_PH_Z_CODE 2'h3
`define TMRVD_GAP_W 2
`endif

// ### pkg/tmrvd_pkg.sv
// Types shared by the TMR voter block
`include "tmrvd_consts.svh"
package tmrvd_pkg;
    typedef logic [`TMRVD_SIG_W-1:0] tmrvd_sig_t;
    typedef logic [`TMRVD_OP_W-1:0] tmrvd_op_t;
    typedef logic [`TMRVD_MEM_W-1:0] tmrvd_mem_t;
    typedef struct packed {
        tmrvd_sig_t ch2;
        tmrvd_sig_t ch1;
        tmrvd_sig_t ch0;
    } tmrvd_sig_trio_t;
    typedef struct packed {
        tmrvd_op_t ch2;
        tmrvd_op_t ch1;
        tmrvd_op_t ch0;
    } tmrvd_op_trio_t;
    typedef struct packed {
        tmrvd_mem_t ch2;
        tmrvd_mem_t ch1;
        tmrvd_mem_t ch0;
    } tmrvd_mem_trio_t;
    typedef enum logic [`TMRVD_PH_W-1:0] {
        TMRVD_PH_W = 2'h0,
        TMRVD_PH_X = 2'h1,
        TMRVD_PH_Y = 2'h2,
        TMRVD_PH_Z = 2'h3
    } tmrvd_phase_t;
endpackage

// ### rtl/tmrvd_voter.sv
// Voter trio with clocked disagreement detector
`timescale 1ns/100ps
`default_nettype none
module tmrvd_voter #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Channel copies
    input wire logic [WIDTH-1:0] ch0_in,
    input wire logic [WIDTH-1:0] ch1_in,
    input wire logic [WIDTH-1:0] ch2_in,
    // Detector sample strobe
    input wire logic sample_in,
    // Voted copies and flag
    output logic [WIDTH-1:0] voted0_out,
    output logic [WIDTH-1:0] voted1_out,
    output logic [WIDTH-1:0] voted2_out,
    output logic disagree_out
);
    logic [WIDTH-1:0] maj;

    initial begin
        if (WIDTH < 1) begin
            $error("tmrvd_voter: WIDTH must be at least 1");
        end
    end

    // Bitwise two of three
    assign maj = (ch0_in & ch1_in) | (ch1_in & ch2_in) | (ch0_in & ch2_in);

    // One driver per channel
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            voted0_out <= '0;
            voted1_out <= '0;
            voted2_out <= '0;
        end else begin
            voted0_out <= maj;
            voted1_out <= maj;
            voted2_out <= maj;
        end
    end

    // Flag held until next sample
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            disagree_out <= 1'b0;
        end else if (sample_in) begin
            disagree_out <= (ch0_in != ch1_in) || (ch1_in != ch2_in);
        end
    end
endmodule
`default_nettype wire

// ### rtl/tmrvd_top.sv
// TMR voting and disagreement detection for one computer channel set
`timescale 1ns/100ps
`default_nettype none
`include "tmrvd_consts.svh"
module tmrvd_top
    import tmrvd_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // General voted signal, one copy per channel
    input wire tmrvd_sig_trio_t sig_in,
    // Op code load, per channel
    input wire tmrvd_op_trio_t op_data_in,
    input wire logic op_load_in,
    // Position-twelve transfer latch, per channel
    input wire logic [2:0] transfer_reg_position_twelve_data_in,
    input wire logic transfer_reg_position_twelve_load_in,
    // Memory interface signal, per channel
    input wire tmrvd_mem_trio_t mem_in,
    // Phase of the four-pulse cycle
    output tmrvd_phase_t phase_out,
    // General signal results
    output tmrvd_sig_trio_t sig_voted_out,
    output logic sig_disagree_out,
    // Op code results
    output tmrvd_op_trio_t op_voted_out,
    output logic op_disagree_out,
    // Transfer latch results
    output logic [2:0] transfer_reg_position_twelve_out,
    output logic transfer_reg_position_twelve_disagree_out,
    // Memory voter pair
    output tmrvd_mem_t mem_even_out,
    output tmrvd_mem_t mem_odd_out,
    output logic mem_disagree_out
);
    ////////////////////////////////////////////////////////////////////////
    tmrvd_phase_t phase_q;
    tmrvd_phase_t phase_d;
    tmrvd_sig_trio_t sig_prev_q;
    logic [`TMRVD_GAP_W-1:0] sig_chg_q;
    logic sig_chg;
    tmrvd_mem_trio_t mem_prev_q;
    logic [`TMRVD_GAP_W-1:0] mem_chg_q;
    logic mem_chg;
    tmrvd_op_trio_t op_q;
    logic [2:0] transfer_reg_position_twelve_q;
    logic at_w;

    ////////////////////////////////////////////////////////////////////////
    // Four-pulse phase sequencer W, X, Y, Z
    always_comb begin
        case (phase_q)
            TMRVD_PH_W: phase_d = TMRVD_PH_X;
            TMRVD_PH_X: phase_d = TMRVD_PH_Y;
            TMRVD_PH_Y: phase_d = TMRVD_PH_Z;
            TMRVD_PH_Z: phase_d = TMRVD_PH_W;
            default: phase_d = TMRVD_PH_W;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            phase_q <= TMRVD_PH_W;
        end else begin
            phase_q <= phase_d;
        end
    end

    assign phase_out = phase_q;
    assign at_w = (phase_q == TMRVD_PH_W);

    ////////////////////////////////////////////////////////////////////////
    // Op code register loads only at X and Y
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            op_q <= '0;
        end else if (op_load_in &&
                     (phase_q == TMRVD_PH_X || phase_q == TMRVD_PH_Y)) begin
            op_q <= op_data_in;
        end
    end

    // Transfer latch loads at X, Y or Z, never at W
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            transfer_reg_position_twelve_q <= 3'h0;
        end else if (transfer_reg_position_twelve_load_in && !at_w) begin
            transfer_reg_position_twelve_q <= transfer_reg_position_twelve_data_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Change trackers: sample two pulses after the last change
    assign sig_chg = (sig_in != sig_prev_q);
    assign mem_chg = (mem_in != mem_prev_q);

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            sig_prev_q <= '0;
            sig_chg_q <= '0;
        end else begin
            sig_prev_q <= sig_in;
            sig_chg_q <= {sig_chg_q[0], sig_chg};
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            mem_prev_q <= '0;
            mem_chg_q <= '0;
        end else begin
            mem_prev_q <= mem_in;
            mem_chg_q <= {mem_chg_q[0], mem_chg};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Voter trios
    tmrvd_voter #(.WIDTH(`TMRVD_SIG_W)) u_sig (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .ch0_in(sig_in.ch0),
        .ch1_in(sig_in.ch1),
        .ch2_in(sig_in.ch2),
        .sample_in(sig_chg_q[1] && !sig_chg_q[0] && !sig_chg),
        .voted0_out(sig_voted_out.ch0),
        .voted1_out(sig_voted_out.ch1),
        .voted2_out(sig_voted_out.ch2),
        .disagree_out(sig_disagree_out)
    );

    // Op code settles by Y, sampled two pulses later at W
    tmrvd_voter #(.WIDTH(`TMRVD_OP_W)) u_op (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .ch0_in(op_q.ch0),
        .ch1_in(op_q.ch1),
        .ch2_in(op_q.ch2),
        .sample_in(at_w),
        .voted0_out(op_voted_out.ch0),
        .voted1_out(op_voted_out.ch1),
        .voted2_out(op_voted_out.ch2),
        .disagree_out(op_disagree_out)
    );

    tmrvd_voter #(.WIDTH(1)) u_transfer_reg_position_twelve (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .ch0_in(transfer_reg_position_twelve_q[0]),
        .ch1_in(transfer_reg_position_twelve_q[1]),
        .ch2_in(transfer_reg_position_twelve_q[2]),
        .sample_in(at_w),
        .voted0_out(transfer_reg_position_twelve_out[0]),
        .voted1_out(transfer_reg_position_twelve_out[1]),
        .voted2_out(transfer_reg_position_twelve_out[2]),
        .disagree_out(transfer_reg_position_twelve_disagree_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // Memory duo: even and odd module drivers
    tmrvd_voter #(.WIDTH(`TMRVD_MEM_W)) u_mem (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .ch0_in(mem_in.ch0),
        .ch1_in(mem_in.ch1),
        .ch2_in(mem_in.ch2),
        .sample_in(mem_chg_q[1] && !mem_chg_q[0] && !mem_chg),
        .voted0_out(mem_even_out),
        .voted1_out(mem_odd_out),
        .voted2_out(),
        .disagree_out(mem_disagree_out)
    );
endmodule
`default_nettype wire

// ### testbench/tmrvd_top_monitor.sv
// Assertion checker for the TMR voter top
`timescale 1ns/100ps
`default_nettype none
module tmrvd_top_monitor
    import tmrvd_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Observed ports
    input wire tmrvd_sig_trio_t sig_in,
    input wire tmrvd_mem_trio_t mem_in,
    input wire tmrvd_phase_t phase_out,
    input wire tmrvd_sig_trio_t sig_voted_out,
    input wire logic sig_disagree_out,
    input wire tmrvd_op_trio_t op_voted_out,
    input wire logic op_disagree_out,
    input wire logic [2:0] transfer_reg_position_twelve_out,
    input wire logic transfer_reg_position_twelve_disagree_out,
    input wire tmrvd_mem_t mem_even_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);
    function automatic logic [15:0] maj(logic [15:0] a, b, c);
        return (a & b) | (b & c) | (a & c);
    endfunction
    ////////////////////////////////////////////////////////////////////////
    property p_phase;
        rstn_in |=> phase_out == 2'($past(phase_out) + 2'h1);
    endproperty
    a_phase: assert property (p_phase) else $error("phase skipped");
    property p_sig_vote;
        rstn_in |=> sig_voted_out == {3{8'(maj($past(sig_in.ch0),
            $past(sig_in.ch1), $past(sig_in.ch2)))}};
    endproperty
    a_sig_vote: assert property (p_sig_vote) else $error("sig vote");
    property p_sig_dis;
        $past(rstn_in, 3) && $past(rstn_in, 2) && $past(rstn_in)
            && $past(sig_in, 2) != $past(sig_in, 3)
            && sig_in == $past(sig_in) && sig_in == $past(sig_in, 2)
            |=> sig_disagree_out == $past(sig_in.ch0 != sig_in.ch1
            || sig_in.ch1 != sig_in.ch2);
    endproperty
    a_sig_dis: assert property (p_sig_dis) else $error("sig sample");
    property p_sig_hold;
        sig_in != $past(sig_in) |=> $stable(sig_disagree_out);
    endproperty
    a_sig_hold: assert property (p_sig_hold) else $error("sig hold");
    property p_op_vote;
        phase_out == TMRVD_PH_W || phase_out == TMRVD_PH_X
            |=> $stable(op_voted_out);
    endproperty
    a_op_vote: assert property (p_op_vote) else $error("op moved");
    property p_op_hold;
        phase_out != TMRVD_PH_W |=> $stable(op_disagree_out);
    endproperty
    a_op_hold: assert property (p_op_hold) else $error("op flag");
    property p_transfer_reg_position_twelve_hold;
        phase_out == TMRVD_PH_X |=> $stable(transfer_reg_position_twelve_out);
    endproperty
    a_transfer_reg_position_twelve_hold: assert property (p_transfer_reg_position_twelve_hold) else $error("transfer_reg_position_twelve");
    property p_transfer_reg_position_twelve_dis;
        phase_out != TMRVD_PH_W |=> $stable(transfer_reg_position_twelve_disagree_out);
    endproperty
    a_transfer_reg_position_twelve_dis: assert property (p_transfer_reg_position_twelve_dis) else $error("transfer_reg_position_twelve flag");
    property p_mem;
        rstn_in |=> mem_even_out == maj($past(mem_in.ch0),
            $past(mem_in.ch1), $past(mem_in.ch2));
    endproperty
    a_mem: assert property (p_mem) else $error("mem vote");
endmodule
`default_nettype wire

// ### testbench/tmrvd_chan_model.sv
// Three-channel source model with single-channel fault injection
`timescale 1ns/100ps
`default_nettype none
module tmrvd_chan_model #(
    parameter int W = 8
) (
    // Common value and fault
    input wire logic [W-1:0] val_in,
    input wire logic [W-1:0] flip_in,
    input wire logic [1:0] bad_ch_in,
    // Channel copies ch2,ch1,ch0
    output logic [3*W-1:0] trio_out
);
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            trio_out[i*W +: W] = val_in ^ ((bad_ch_in == i) ? flip_in : '0);
        end
    end
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the TMR voter top
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import tmrvd_pkg::*;
    logic clk_in, rstn_in, op_load_in, transfer_reg_position_twelve_load_in, exp_od, exp_td;
    logic sig_disagree_out, op_disagree_out, transfer_reg_position_twelve_disagree_out;
    logic mem_disagree_out;
    logic [1:0] sb, mb, ob;
    logic [2:0] transfer_reg_position_twelve_data_in, exp_t, transfer_reg_position_twelve_out;
    logic [7:0] sv, sf, ov, of, exp_op;
    logic [15:0] mv, mf;
    tmrvd_sig_trio_t sig_in, sig_voted_out;
    tmrvd_op_trio_t op_data_in, op_voted_out;
    tmrvd_mem_trio_t mem_in;
    tmrvd_phase_t phase_out;
    tmrvd_mem_t mem_even_out, mem_odd_out;
    int n_errors, total_checks, seed;
    tmrvd_chan_model #(.W(8)) u_sig (.val_in(sv), .flip_in(sf),
        .bad_ch_in(sb), .trio_out(sig_in));
    tmrvd_chan_model #(.W(8)) u_op (.val_in(ov), .flip_in(of),
        .bad_ch_in(ob), .trio_out(op_data_in));
    tmrvd_chan_model #(.W(16)) u_mem (.val_in(mv), .flip_in(mf),
        .bad_ch_in(mb), .trio_out(mem_in));
    tmrvd_top u_dut (.clk_in, .rstn_in, .sig_in, .op_data_in, .op_load_in,
        .transfer_reg_position_twelve_data_in, .transfer_reg_position_twelve_load_in, .mem_in, .phase_out, .sig_voted_out,
        .sig_disagree_out, .op_voted_out, .op_disagree_out,
        .transfer_reg_position_twelve_out, .transfer_reg_position_twelve_disagree_out,
        .mem_even_out, .mem_odd_out, .mem_disagree_out);
    function automatic logic maj(input logic a, b, c);
        return (a & b) | (b & c) | (a & c);
    endfunction
    task automatic chk(input logic ok, input string what);
        total_checks++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    initial begin
        #40000;
        n_errors++;
        finish_test;
    end
    initial begin
        seed = 15536;
        {sv, sf, ov, of, mv, mf, sb, mb, ob, exp_op, exp_t} = '0;
        {op_load_in, transfer_reg_position_twelve_load_in, transfer_reg_position_twelve_data_in, rstn_in} = '0;
        {exp_od, exp_td} = '0;
        repeat (3) @(negedge clk_in);
        chk(phase_out === TMRVD_PH_W && sig_voted_out === '0, "reset");
        rstn_in = 1'b1;
        for (int it = 0; it < 200; it++) begin
            while (phase_out !== TMRVD_PH_W) @(negedge clk_in);
            // New values change on one pulse only, then hold
            {sb, sf, sv} = 18'($random(seed));
            {ob, of, ov, op_load_in} = 19'($random(seed));
            {transfer_reg_position_twelve_load_in, transfer_reg_position_twelve_data_in} = 4'($random(seed));
            {mb, mf, mv} = 34'({$random(seed), $random(seed)});
            if (it < 4) {sb, mb, ob} = {3{2'(it)}};
            if (op_load_in) begin
                exp_op = ov;
                exp_od = ob != 2'h3 && of != 8'h00;
            end
            if (transfer_reg_position_twelve_load_in) begin
                exp_t = {3{maj(transfer_reg_position_twelve_data_in[0], transfer_reg_position_twelve_data_in[1],
                    transfer_reg_position_twelve_data_in[2])}};
                exp_td = transfer_reg_position_twelve_data_in != 3'h0 && transfer_reg_position_twelve_data_in != 3'h7;
            end
            @(negedge clk_in);
            chk(sig_voted_out === {3{sv}}, "sig vote");
            chk(mem_even_out === mv && mem_odd_out === mv, "mem vote");
            repeat (2) @(negedge clk_in);
            chk(sig_disagree_out === (sb != 2'h3 && sf != 8'h00), "sd");
            chk(mem_disagree_out === (mb != 2'h3 && mf != 16'h0), "md");
            repeat (2) @(negedge clk_in);
            chk(op_voted_out === {3{exp_op}}, "op vote");
            chk(op_disagree_out === exp_od, "op flag");
            chk(transfer_reg_position_twelve_out === exp_t, "transfer_reg_position_twelve");
            chk(transfer_reg_position_twelve_disagree_out === exp_td, "transfer_reg_position_twelve flag");
        end
        finish_test;
    end
endmodule
bind tmrvd_top tmrvd_top_monitor u_mon (.clk_in, .rstn_in, .sig_in,
    .mem_in, .phase_out, .sig_voted_out, .sig_disagree_out, .op_voted_out,
    .op_disagree_out, .transfer_reg_position_twelve_out,
    .transfer_reg_position_twelve_disagree_out, .mem_even_out);
`default_nettype wire
